// File: keypad_irq_pkg.sv
// Overview of operation
// - five keypad pins, each separately enabled
// - per-pin enable bit selects keypad function
// - enabled pin switches on its pullup
// - latch when enabled pin falls after all high
// - edge mode ignores fall while another low
// - level mode holds request while any low
// - level mode clears after acknowledge and release
// - vector fetch acknowledges the request
// - writing one to acknowledge bit acknowledges
// - acknowledge never hides later falling edges
// - unmasked pending request drives processor request
// - edge mode clears at once on acknowledge
// - reset clears request and sensitivity bit
// - pending flag readable regardless of mask
// - enable forces input, reads need direction zero
// - acknowledge bit is write-only, reads zero
// - mask bit one blocks requests, reset clears
// - sensitivity one edge plus level, zero edge
// - break without clear enable ignores acknowledge writes
package keypad_irq_pkg;

  // ==========================================================================
  // widths
  localparam int PIN_COUNT = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] PIN_ENABLE_OFFSET = 8'h01;

  // ==========================================================================
  // keypad_status_control field positions
  localparam int SENS_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int FLAG_BIT = 3;

  // ==========================================================================
  // reset values
  localparam logic [PIN_COUNT-1:0] PIN_ENABLE_RESET = 5'h00;
  localparam logic [PIN_COUNT-1:0] PIN_LEVEL_RESET = 5'h1f;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic irq_mask;
    logic level_sensitivity_select;
  } ctrl_t;

  typedef enum logic [1:0] {
    REQ_IDLE,
    REQ_PENDING,
    REQ_ACKED_LOW
  } req_state_t;

  // true when any enabled pin reads low
  function automatic logic any_enabled_low(input logic [PIN_COUNT-1:0] en,
                                           input logic [PIN_COUNT-1:0] lvl);
    any_enabled_low = |(en & ~lvl);
  endfunction : any_enabled_low

endpackage : keypad_irq_pkg

// File: keypad_irq_unit.sv
`timescale 1ns/100ps
module keypad_irq_unit
  import keypad_irq_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // keypad pads and port control
  input wire logic [PIN_COUNT-1:0] pin_level_i,
  input wire logic [PIN_COUNT-1:0] port_dir_out_i,
  output logic [PIN_COUNT-1:0] pullup_en_o,
  output logic [PIN_COUNT-1:0] port_drive_oe_n_o,
  output logic [PIN_COUNT-1:0] pin_read_allow_o,
  // processor side
  input wire logic vector_fetch_i,
  input wire logic break_state_i,
  input wire logic break_clear_enable_i,
  output logic irq_req_o
);

  // ==========================================================================
  // declarations
  bus_req_t bus;
  ctrl_t ctrl_q;
  logic [PIN_COUNT-1:0] pin_irq_enable_q;
  logic [PIN_COUNT-1:0] pin_sync;
  logic any_low;
  logic all_high_q;
  logic falling;
  logic set_req;
  logic sw_ack;
  logic ack;
  logic sc_write;
  logic en_write;
  req_state_t state_q;
  req_state_t state_d;
  logic irq_pending_flag;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ==========================================================================
  // pin synchronisation
  pin_synchronizer u_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .pin_raw_i(pin_level_i),
    .pin_level_o(pin_sync)
  );

  // ==========================================================================
  // address decode
  assign sc_write = bus.wr && (bus.addr == STATUS_CONTROL_OFFSET);
  assign en_write = bus.wr && (bus.addr == PIN_ENABLE_OFFSET);

  // ==========================================================================
  // pin enable register, one bit per pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_irq_enable_q <= PIN_ENABLE_RESET;
    end else if (en_write) begin
      pin_irq_enable_q <= bus.wdata[PIN_COUNT-1:0];
    end
  end

  // ==========================================================================
  // mask and sensitivity bits
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= '0;
    end else if (sc_write) begin
      ctrl_q.irq_mask <= bus.wdata[MASK_BIT];
      ctrl_q.level_sensitivity_select <= bus.wdata[SENS_BIT];
    end
  end

  // ==========================================================================
  // acknowledge sources; a break without clear enable protects the flag from software acknowledge only, not vector fetch
  assign sw_ack = sc_write && bus.wdata[ACK_BIT]
                  && !(break_state_i && !break_clear_enable_i);
  assign ack = vector_fetch_i || sw_ack;

  // ==========================================================================
  // edge detection on the filtered levels of enabled pins only
  assign any_low = any_enabled_low(pin_irq_enable_q, pin_sync);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      all_high_q <= 1'b1;
    end else begin
      all_high_q <= !any_low;
    end
  end

  // a fall while another pin is low is not a new edge
  assign falling = any_low && all_high_q;
  assign set_req = falling || (ctrl_q.level_sensitivity_select && any_low);

  // ==========================================================================
  // request state; a set in the ack cycle wins so no edge is lost
  always_comb begin
    state_d = state_q;
    case (state_q)
      REQ_IDLE: begin
        if (set_req) begin
          state_d = REQ_PENDING;
        end
      end
      REQ_PENDING: begin
        if (ack) begin
          if (!ctrl_q.level_sensitivity_select) begin
            state_d = falling ? REQ_PENDING : REQ_IDLE;
          end else if (any_low) begin
            state_d = REQ_ACKED_LOW;
          end else begin
            state_d = REQ_IDLE;
          end
        end
      end
      REQ_ACKED_LOW: begin
        // leaving level mode drops the wait for release
        if (!any_low || !ctrl_q.level_sensitivity_select) begin
          state_d = REQ_IDLE;
        end
      end
      default: begin
        state_d = REQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= REQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // acknowledged-but-held still counts as a present request
  assign irq_pending_flag = (state_q != REQ_IDLE);

  // ==========================================================================
  // processor request, gated only by the mask
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o <= irq_pending_flag && !ctrl_q.irq_mask;
    end
  end

  // ==========================================================================
  // port control: enable forces input and pullup
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pullup_en_o <= PIN_ENABLE_RESET;
      port_drive_oe_n_o <= ~PIN_ENABLE_RESET;
      pin_read_allow_o <= PIN_ENABLE_RESET;
    end else begin
      pullup_en_o <= pin_irq_enable_q;
      port_drive_oe_n_o <= ~(port_dir_out_i & ~pin_irq_enable_q);
      pin_read_allow_o <= ~port_dir_out_i;
    end
  end

  // ==========================================================================
  // read data, valid in the cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= READ_ZERO;
    end else begin
      reg_rdata_o <= READ_ZERO;
      if (bus.rd) begin
        if (bus.addr == STATUS_CONTROL_OFFSET) begin
          reg_rdata_o[FLAG_BIT] <= irq_pending_flag;
          reg_rdata_o[ACK_BIT] <= 1'b0;
          reg_rdata_o[MASK_BIT] <= ctrl_q.irq_mask;
          reg_rdata_o[SENS_BIT] <= ctrl_q.level_sensitivity_select;
        end else if (bus.addr == PIN_ENABLE_OFFSET) begin
          reg_rdata_o[PIN_COUNT-1:0] <= pin_irq_enable_q;
        end
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_edge_latches: assert property (
    (state_q == REQ_IDLE && falling) |=> irq_pending_flag
  ) else $error("falling edge did not latch request");

  a_edge_blocked: assert property (
    (state_q == REQ_IDLE && !ctrl_q.level_sensitivity_select && !all_high_q)
    |=> (state_q == REQ_IDLE)
  ) else $error("request latched while another pin low");

  a_level_holds: assert property (
    (ctrl_q.level_sensitivity_select && any_low && irq_pending_flag
     && $stable(ctrl_q.level_sensitivity_select))
    |=> irq_pending_flag
  ) else $error("level request dropped while pin low");

  a_level_release: assert property (
    (state_q == REQ_ACKED_LOW && !any_low) |=> (state_q == REQ_IDLE)
  ) else $error("acked request not cleared on release");

  a_vector_ack: assert property (
    (state_q == REQ_PENDING && vector_fetch_i && !ctrl_q.level_sensitivity_select && !falling)
    |=> !irq_pending_flag
  ) else $error("vector fetch did not clear request");

  a_soft_ack: assert property (
    (sc_write && bus.wdata[ACK_BIT] && !break_state_i) |-> ack
  ) else $error("software acknowledge not generated");

  a_ack_edge_wins: assert property (
    (ack && falling) |=> irq_pending_flag
  ) else $error("edge lost on acknowledge cycle");

  a_req_output: assert property (
    (irq_pending_flag && !ctrl_q.irq_mask) |=> irq_req_o
  ) else $error("unmasked request not raised");

  a_mask_blocks: assert property (
    ctrl_q.irq_mask |=> !irq_req_o
  ) else $error("masked request reached processor");

  a_flag_read: assert property (
    (bus.rd && bus.addr == STATUS_CONTROL_OFFSET)
    |=> (reg_rdata_o[FLAG_BIT] == $past(irq_pending_flag) && !reg_rdata_o[ACK_BIT])
  ) else $error("status read mismatch");

  a_pullup_follow: assert property (
    ##1 (pullup_en_o == $past(pin_irq_enable_q))
  ) else $error("pullup does not follow enable");

  a_force_input: assert property (
    ##1 ((~port_drive_oe_n_o & $past(pin_irq_enable_q)) == '0)
  ) else $error("enabled pin still driven");

  a_break_protect: assert property (
    (break_state_i && !break_clear_enable_i && !vector_fetch_i) |-> !ack
  ) else $error("acknowledge taken during protected break");

  // ==========================================================================
  // register write and read checks
  a_enable_write: assert property (
    en_write |=> (pin_irq_enable_q == $past(reg_wdata_i[PIN_COUNT-1:0]))
  ) else $error("pin enable write not taken");

  a_sens_write: assert property (
    sc_write |=> (ctrl_q.level_sensitivity_select == $past(reg_wdata_i[SENS_BIT]))
  ) else $error("sensitivity write not taken");

  a_mask_write: assert property (
    sc_write |=> (ctrl_q.irq_mask == $past(reg_wdata_i[MASK_BIT]))
  ) else $error("mask write not taken");

  a_enable_read: assert property (
    (bus.rd && bus.addr == PIN_ENABLE_OFFSET)
    |=> (reg_rdata_o == {{(DATA_W-PIN_COUNT){1'b0}}, $past(pin_irq_enable_q)})
  ) else $error("pin enable read mismatch");

  a_ack_bit_read: assert property (
    bus.rd |=> !reg_rdata_o[ACK_BIT]
  ) else $error("acknowledge bit read back as one");

  a_rdata_idle: assert property (
    !bus.rd |=> (reg_rdata_o == READ_ZERO)
  ) else $error("read data left standing");

  // ==========================================================================
  // request life cycle checks
  a_idle_quiet: assert property (
    (state_q == REQ_IDLE && !any_low) |=> (state_q == REQ_IDLE)
  ) else $error("request latched with enabled pins high");

  a_pending_stays: assert property (
    (state_q == REQ_PENDING && !ack) |=> irq_pending_flag
  ) else $error("pending request dropped without acknowledge");

  a_soft_clear: assert property (
    (state_q == REQ_PENDING && sw_ack && !ctrl_q.level_sensitivity_select && !falling)
    |=> !irq_pending_flag
  ) else $error("software acknowledge did not clear request");

  a_vector_level: assert property (
    (state_q == REQ_PENDING && vector_fetch_i && ctrl_q.level_sensitivity_select && !any_low)
    |=> (state_q == REQ_IDLE)
  ) else $error("vector fetch with pins high did not clear");

  a_ack_while_low: assert property (
    (state_q == REQ_PENDING && ctrl_q.level_sensitivity_select && ack && any_low)
    |=> (state_q == REQ_ACKED_LOW)
  ) else $error("level request cleared while pin low");

  a_acked_holds: assert property (
    (state_q == REQ_ACKED_LOW && any_low && ctrl_q.level_sensitivity_select)
    |=> (state_q == REQ_ACKED_LOW)
  ) else $error("acked request released while pin low");

  a_level_sets: assert property (
    (ctrl_q.level_sensitivity_select && any_low) |=> irq_pending_flag
  ) else $error("low level did not hold request");

  a_break_allowed: assert property (
    (sc_write && bus.wdata[ACK_BIT] && break_state_i && break_clear_enable_i) |-> sw_ack
  ) else $error("acknowledge refused with clear enable set");

  // ==========================================================================
  // scenario covers
  c_edge_irq: cover property (
    !ctrl_q.irq_mask && falling ##[1:3] irq_req_o
  );

  c_level_release: cover property (
    state_q == REQ_ACKED_LOW ##[1:20] state_q == REQ_IDLE
  );

  c_soft_ack: cover property (
    state_q == REQ_PENDING && sw_ack ##1 state_q == REQ_IDLE
  );

  c_masked_poll: cover property (
    ctrl_q.irq_mask && irq_pending_flag ##1 bus.rd
  );

  c_break_refused: cover property (
    break_state_i && !break_clear_enable_i && sc_write && bus.wdata[ACK_BIT]
  );

endmodule : keypad_irq_unit

// File: keypad_irq_unit_tb_top.sv
`timescale 1ns/100ps
// ============================================================================
// stimulus and checking for the keypad interrupt unit
module keypad_irq_unit_tb_top
  import keypad_irq_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = 8'h00;
  logic [DATA_W-1:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic vector_fetch_i = 1'b0;
  logic break_state_i = 1'b0;
  logic break_clear_enable_i = 1'b0;
  logic [PIN_COUNT-1:0] port_dir_out_i = 5'h0a;
  logic [PIN_COUNT-1:0] press_q = 5'h00;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [PIN_COUNT-1:0] pin_level_i;
  logic [PIN_COUNT-1:0] pullup_en_o;
  logic [PIN_COUNT-1:0] port_drive_oe_n_o;
  logic [PIN_COUNT-1:0] pin_read_allow_o;
  logic irq_req_o;
  logic [DATA_W-1:0] rv;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  keypad_irq_unit u_keypad_irq_unit (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pin_level_i, .port_dir_out_i, .pullup_en_o, .port_drive_oe_n_o, .pin_read_allow_o,
    .vector_fetch_i, .break_state_i, .break_clear_enable_i, .irq_req_o);
  keypad_switch_model u_keypad_switch_model (.core_clk_i, .press_i(press_q), .pullup_en_i(pullup_en_o),
    .pad_o(pin_level_i));

  // ==========================================================================
  // clock and hang guard; the whole run needs well under a thousand cycles
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask : rd
  // key changes pass a synchroniser and filter, so allow eight cycles
  task automatic press(input logic [4:0] m);
    @(posedge core_clk_i);
    press_q <= m;
    tick(8);
  endtask : press
  task automatic fetch();
    @(posedge core_clk_i);
    vector_fetch_i <= 1'b1;
    @(posedge core_clk_i);
    vector_fetch_i <= 1'b0;
    tick(3);
  endtask : fetch
  // masked enable then acknowledge, so pullup settling raises nothing
  task automatic init(input logic sens);
    wr(STATUS_CONTROL_OFFSET, 8'h02);
    wr(PIN_ENABLE_OFFSET, 8'h1f);
    tick(8);
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    wr(STATUS_CONTROL_OFFSET, {7'h00, sens});
  endtask : init

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    wr(8'h05, 8'hff);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h00);
    rd(PIN_ENABLE_OFFSET, rv);
    chk(rv, 8'h00);
    chk({3'h0, pullup_en_o}, 8'h00);
    chk({3'h0, port_drive_oe_n_o}, 8'h15);
    chk({3'h0, pin_read_allow_o}, 8'h15);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edge();
    init(1'b0);
    chk({3'h0, pullup_en_o}, 8'h1f);
    chk({3'h0, port_drive_oe_n_o}, 8'h1f);
    chk({3'h0, pin_read_allow_o}, 8'h15);
    press(5'h01);
    chk({7'h0, irq_req_o}, 8'h01);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h08);
    fetch();
    chk({7'h0, irq_req_o}, 8'h00);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h00);
    press(5'h03);
    chk({7'h0, irq_req_o}, 8'h00);
    press(5'h00);
    press(5'h02);
    chk({7'h0, irq_req_o}, 8'h01);
    wr(STATUS_CONTROL_OFFSET, 8'h04);
    wr(PIN_ENABLE_OFFSET, 8'h1d);
    press(5'h06);
    chk({7'h0, irq_req_o}, 8'h01);
    wr(STATUS_CONTROL_OFFSET, 8'h04);
    tick(3);
    chk({7'h0, irq_req_o}, 8'h00);
    press(5'h00);
    wr(PIN_ENABLE_OFFSET, 8'h1f);
    tick(8);
    wr(STATUS_CONTROL_OFFSET, 8'h04);
    $display("test edge done");
  endtask : t_edge
  task automatic t_mask();
    wr(STATUS_CONTROL_OFFSET, 8'h02);
    press(5'h04);
    chk({7'h0, irq_req_o}, 8'h00);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h0a);
    @(posedge core_clk_i);
    break_state_i <= 1'b1;
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h0a);
    @(posedge core_clk_i);
    break_clear_enable_i <= 1'b1;
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h02);
    @(posedge core_clk_i);
    break_state_i <= 1'b0;
    break_clear_enable_i <= 1'b0;
    press(5'h00);
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    press(5'h10);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h0a);
    wr(STATUS_CONTROL_OFFSET, 8'h06);
    press(5'h00);
    $display("test mask done");
  endtask : t_mask
  task automatic t_level();
    wr(STATUS_CONTROL_OFFSET, 8'h01);
    press(5'h08);
    chk({7'h0, irq_req_o}, 8'h01);
    fetch();
    chk({7'h0, irq_req_o}, 8'h01);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h09);
    press(5'h00);
    chk({7'h0, irq_req_o}, 8'h00);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h01);
    press(5'h08);
    press(5'h00);
    chk({7'h0, irq_req_o}, 8'h01);
    wr(STATUS_CONTROL_OFFSET, 8'h05);
    tick(3);
    chk({7'h0, irq_req_o}, 8'h00);
    wr(PIN_ENABLE_OFFSET, 8'h17);
    tick(1);
    chk({3'h0, pullup_en_o}, 8'h17);
    // all pins asked to drive: only the disabled pin may, and none may be read
    @(posedge core_clk_i);
    port_dir_out_i <= 5'h1f;
    tick(2);
    chk({3'h0, port_drive_oe_n_o}, 8'h17);
    chk({3'h0, pin_read_allow_o}, 8'h00);
    @(posedge core_clk_i);
    port_dir_out_i <= 5'h0a;
    press(5'h08);
    chk({7'h0, irq_req_o}, 8'h00);
    press(5'h00);
    $display("test level done");
  endtask : t_level
  task automatic t_reset_held();
    wr(PIN_ENABLE_OFFSET, 8'h1f);
    tick(8);
    wr(STATUS_CONTROL_OFFSET, 8'h05);
    press(5'h01);
    chk({7'h0, irq_req_o}, 8'h01);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    tick(2);
    chk({3'h0, port_drive_oe_n_o}, 8'h1f);
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    tick(2);
    rd(STATUS_CONTROL_OFFSET, rv);
    chk(rv, 8'h00);
    chk({7'h0, irq_req_o}, 8'h00);
    $display("test reset held done");
  endtask : t_reset_held

  // ==========================================================================
  // verdict, the single place the run ends
  task automatic results();
    $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_edge();
    t_mask();
    t_level();
    t_reset_held();
    results();
  end
endmodule : keypad_irq_unit_tb_top

// File: keypad_switch_model.sv
`timescale 1ns/100ps
// ============================================================================
// keypad switches and pads on the far side of the port pins
module keypad_switch_model
  import keypad_irq_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // key presses and pullup control
  input wire logic [PIN_COUNT-1:0] press_i,
  input wire logic [PIN_COUNT-1:0] pullup_en_i,
  // pad levels
  output logic [PIN_COUNT-1:0] pad_o
);
  // an undriven pad wanders every cycle so it never passes for a steady level
  logic [PIN_COUNT-1:0] float_q = 5'h0a;
  always @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end
  // a closed key pulls low, otherwise the pullup or the wandering float
  assign pad_o = ~press_i & (pullup_en_i | float_q);
endmodule : keypad_switch_model

// File: pin_synchronizer.sv
`timescale 1ns/100ps
module pin_synchronizer
  import keypad_irq_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // raw pad levels
  input wire logic [PIN_COUNT-1:0] pin_raw_i,
  // filtered levels
  output logic [PIN_COUNT-1:0] pin_level_o
);

  logic [PIN_COUNT-1:0] stage1_q;
  logic [PIN_COUNT-1:0] stage2_q;
  logic [PIN_COUNT-1:0] stage3_q;

  // ==========================================================================
  // three-flop chain; stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_q <= PIN_LEVEL_RESET;
      stage2_q <= PIN_LEVEL_RESET;
      stage3_q <= PIN_LEVEL_RESET;
    end else begin
      stage1_q <= pin_raw_i;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // ==========================================================================
  // a bit moves only when stage2 and stage3 agree, rejecting one-cycle glitches
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_level_o <= PIN_LEVEL_RESET;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          pin_level_o[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule : pin_synchronizer
